// *** hdl/shh_pkg.sv ***
// Shared constants and types of the sensor hub host channel register bank
package shh_pkg;
    // ========================================================================
    // Device register offsets
    localparam logic [6:0] OFF_CMD   = 7'h00;
    localparam logic [6:0] OFF_WAKE  = 7'h01;
    localparam logic [6:0] OFF_NWAKE = 7'h02;
    localparam logic [6:0] OFF_STAT  = 7'h03;
    localparam logic [6:0] OFF_RSVD  = 7'h04;
    localparam logic [6:0] OFF_CORE  = 7'h05;
    localparam logic [6:0] OFF_LINK  = 7'h06;
    localparam logic [6:0] OFF_TSREQ = 7'h15;
    localparam logic [6:0] OFF_TS0   = 7'h26;
    localparam logic [6:0] OFF_ERR0  = 7'h2e;

    // ========================================================================
    // Device field positions and reset values
    localparam int         CORE_TURBO_OFF = 0;
    localparam int         CORE_ERR_CLR   = 1;
    localparam int         LINK_ASLEEP    = 4;
    localparam int         LINK_TS_SEL    = 6;
    localparam int         LINK_ASYNC     = 7;
    localparam logic [7:0] LINK_WMASK     = 8'hdf;
    localparam logic [7:0] LINK_RESET     = 8'h00;
    localparam int         NUM_OUT_CHAN   = 3;
    localparam int         ERR_REGS       = 4;
    localparam int         TS_BYTES       = 5;
    localparam logic [15:0] CMD_MIN_PAYLOAD = 16'h0004;

    // ========================================================================
    // Controller registers on AHB-Lite
    localparam logic [31:0] HREG_CMD    = 32'h0000_0000;
    localparam logic [31:0] HREG_STAT   = 32'h0000_0004;
    localparam int          HCMD_WDATA  = 0;
    localparam int          HCMD_ADDR   = 8;
    localparam int          HCMD_WR     = 16;
    localparam int          HSTAT_BUSY  = 8;
    localparam int          HSTAT_IRQ   = 9;
    localparam int          HSTAT_REFUS = 10;

    // ========================================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int ABORT_HOLD_NS  = 2000000;
    localparam int ABORT_HOLD_CYC = (ABORT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum {SHH_IDLE, SHH_BUSY} shh_host_state_t;
endpackage : shh_pkg

// *** hdl/shh_link_if.sv ***
// Byte register link between host controller and sensor hub device
`timescale 1ns/1ps
interface shh_link_if;
    logic       req;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    logic       irq;

    modport dev  (input req, wr, addr, wdata, output rdata, ack, irq);
    modport host (output req, wr, addr, wdata, input rdata, ack, irq);
endinterface : shh_link_if

// *** hdl/shh_device.sv ***
// Sensor hub device end: host channel register bank
`timescale 1ns/1ps
module shh_device (
    input  wire logic        clock,
    input  wire logic        nrst,
    shh_link_if.dev          link,
    output logic             turbo_allowed,
    output logic             err_clear,
    input  wire logic        err_wr,
    input  wire logic [1:0]  err_idx,
    input  wire logic [7:0]  err_data,
    output logic             cmd_start,
    output logic [15:0]      cmd_code,
    output logic [15:0]      cmd_len,
    output logic             cmd_bad,
    output logic             cmd_byte_valid,
    output logic [7:0]       cmd_byte,
    input  wire logic [15:0] chan_len  [shh_pkg::NUM_OUT_CHAN],
    input  wire logic [7:0]  chan_byte [shh_pkg::NUM_OUT_CHAN],
    output logic [2:0]       chan_pop,
    output logic [2:0]       chan_done,
    output logic [3:0]       chan_flush,
    output logic             status_async,
    input  wire logic [39:0] ts_now,
    output logic             ts_event_pkt
);
    // ========================================================================
    // State
    logic        turbo_off,   next_turbo_off;
    logic        clr_q,       next_clr_q;
    logic [7:0]  ctl,         next_ctl;
    logic [7:0]  err   [shh_pkg::ERR_REGS];
    logic [7:0]  next_err [shh_pkg::ERR_REGS];
    logic [39:0] ts_cap,      next_ts_cap;
    logic        irq_q,       next_irq_q;
    logic        ack_q,       next_ack_q;
    logic [7:0]  rdata_q,     next_rdata_q;
    logic [16:0] cmd_cnt,     next_cmd_cnt;
    logic [15:0] code_q,      next_code_q;
    logic [15:0] len_q,       next_len_q;
    logic        start_q,     next_start_q;
    logic        bad_q,       next_bad_q;
    logic        bv_q,        next_bv_q;
    logic [7:0]  byte_q,      next_byte_q;
    logic [16:0] cnt  [shh_pkg::NUM_OUT_CHAN];
    logic [16:0] next_cnt [shh_pkg::NUM_OUT_CHAN];
    logic [15:0] size [shh_pkg::NUM_OUT_CHAN];
    logic [15:0] next_size [shh_pkg::NUM_OUT_CHAN];
    logic [2:0]  pop_q,       next_pop_q;
    logic [2:0]  done_q,      next_done_q;
    logic [3:0]  flush_q,     next_flush_q;
    logic        tspkt_q,     next_tspkt_q;
    logic        take;
    logic        rd;
    logic        wr;
    logic [2:0]  pend;

    assign take = link.req & ~ack_q;
    assign rd   = take & ~link.wr;
    assign wr   = take & link.wr;

    // ========================================================================
    // Next-state logic
    always_comb begin
        next_turbo_off = turbo_off;
        next_clr_q     = 1'b0;
        next_ctl       = ctl;
        next_err       = err;
        next_ts_cap    = ts_cap;
        next_ack_q     = take;
        next_rdata_q   = rdata_q;
        next_cmd_cnt   = cmd_cnt;
        next_code_q    = code_q;
        next_len_q     = len_q;
        next_start_q   = 1'b0;
        next_bad_q     = 1'b0;
        next_bv_q      = 1'b0;
        next_byte_q    = byte_q;
        next_cnt       = cnt;
        next_size      = size;
        next_pop_q     = '0;
        next_done_q    = '0;
        next_flush_q   = '0;
        next_tspkt_q   = 1'b0;
        if (rd) begin
            next_rdata_q = 8'h00;
        end
        if (wr) begin
            if (link.addr == shh_pkg::OFF_CMD) begin
                next_cmd_cnt = cmd_cnt + 17'h00001;
                if (cmd_cnt == 17'h00000) begin
                    next_code_q[7:0] = link.wdata;
                end else if (cmd_cnt == 17'h00001) begin
                    next_code_q[15:8] = link.wdata;
                end else if (cmd_cnt == 17'h00002) begin
                    next_len_q[7:0] = link.wdata;
                end else if (cmd_cnt == 17'h00003) begin
                    next_len_q[15:8] = link.wdata;
                    next_start_q     = 1'b1;
                    if ({link.wdata, len_q[7:0]} == 16'h0000) begin
                        next_cmd_cnt = '0;
                    end else if ({link.wdata, len_q[7:0]} < shh_pkg::CMD_MIN_PAYLOAD) begin
                        next_bad_q = 1'b1;
                    end
                end else begin
                    next_bv_q   = 1'b1;
                    next_byte_q = link.wdata;
                    if (cmd_cnt - 17'h00003 == {1'b0, len_q}) begin
                        next_cmd_cnt = '0;
                    end
                end
            end else if (link.addr == shh_pkg::OFF_CORE) begin
                next_turbo_off = link.wdata[shh_pkg::CORE_TURBO_OFF];
                if (link.wdata[shh_pkg::CORE_ERR_CLR]) begin
                    next_clr_q = 1'b1;
                    for (int i = 0; i < shh_pkg::ERR_REGS; i++) begin
                        next_err[i] = 8'h00;
                    end
                end
            end else if (link.addr == shh_pkg::OFF_LINK) begin
                next_ctl     = link.wdata & shh_pkg::LINK_WMASK;
                next_flush_q = link.wdata[3:0] & ~ctl[3:0];
            end else if (link.addr == shh_pkg::OFF_TSREQ) begin
                if (ctl[shh_pkg::LINK_TS_SEL]) begin
                    next_ts_cap = ts_now;
                end else begin
                    next_tspkt_q = 1'b1;
                end
            end
        end
        // Core writes after a clear so a new error is never lost
        if (err_wr) begin
            next_err[err_idx] = err_data;
        end
        if (ctl[0]) begin
            next_cmd_cnt = '0;
        end
        for (int c = 0; c < shh_pkg::NUM_OUT_CHAN; c++) begin
            if (ctl[c + 1]) begin
                next_cnt[c] = '0;
            end else if (rd && link.addr == shh_pkg::OFF_WAKE + 7'(c)) begin
                if (cnt[c] == 17'h00000) begin
                    // Size frozen here; later samples wait for next session
                    next_size[c]  = chan_len[c];
                    next_rdata_q  = chan_len[c][7:0];
                    next_cnt[c]   = 17'h00001;
                end else if (cnt[c] == 17'h00001) begin
                    next_rdata_q = size[c][15:8];
                    if (size[c] == 16'h0000) begin
                        next_cnt[c]    = '0;
                        next_done_q[c] = 1'b1;
                    end else begin
                        next_cnt[c] = 17'h00002;
                    end
                end else begin
                    next_rdata_q  = chan_byte[c];
                    next_pop_q[c] = 1'b1;
                    if (cnt[c] - 17'h00001 == {1'b0, size[c]}) begin
                        next_cnt[c]    = '0;
                        next_done_q[c] = 1'b1;
                    end else begin
                        next_cnt[c] = cnt[c] + 17'h00001;
                    end
                end
            end
        end
        if (rd) begin
            if (link.addr == shh_pkg::OFF_CORE) begin
                next_rdata_q = {7'h00, turbo_off};
            end else if (link.addr == shh_pkg::OFF_LINK) begin
                next_rdata_q = ctl;
            end else if (link.addr >= shh_pkg::OFF_ERR0 &&
                         link.addr <  shh_pkg::OFF_ERR0 + 7'(shh_pkg::ERR_REGS)) begin
                next_rdata_q = err[2'(link.addr - shh_pkg::OFF_ERR0)];
            end else if (link.addr >= shh_pkg::OFF_TS0 &&
                         link.addr <  shh_pkg::OFF_TS0 + 7'(shh_pkg::TS_BYTES)) begin
                next_rdata_q = ts_cap[8 * 32'(link.addr - shh_pkg::OFF_TS0) +: 8];
            end
        end
        // Pending until drained or aborted
        for (int c = 0; c < shh_pkg::NUM_OUT_CHAN; c++) begin
            pend[c] = ~ctl[c + 1] & ((chan_len[c] != 16'h0000) | (cnt[c] != 17'h00000));
        end
        next_irq_q = pend[0] | (pend[1] & ~ctl[shh_pkg::LINK_ASLEEP]) | pend[2];
        if (next_irq_q && !irq_q && !ctl[shh_pkg::LINK_TS_SEL]) begin
            next_ts_cap = ts_now;
        end
    end

    // ========================================================================
    // Registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            turbo_off <= 1'b0;
            clr_q     <= 1'b0;
            ctl       <= shh_pkg::LINK_RESET;
            err       <= '{default: 8'h00};
            ts_cap    <= '0;
            irq_q     <= 1'b0;
            ack_q     <= 1'b0;
            rdata_q   <= 8'h00;
            cmd_cnt   <= '0;
            code_q    <= '0;
            len_q     <= '0;
            start_q   <= 1'b0;
            bad_q     <= 1'b0;
            bv_q      <= 1'b0;
            byte_q    <= 8'h00;
            cnt       <= '{default: 17'h00000};
            size      <= '{default: 16'h0000};
            pop_q     <= '0;
            done_q    <= '0;
            flush_q   <= '0;
            tspkt_q   <= 1'b0;
        end else begin
            turbo_off <= next_turbo_off;
            clr_q     <= next_clr_q;
            ctl       <= next_ctl;
            err       <= next_err;
            ts_cap    <= next_ts_cap;
            irq_q     <= next_irq_q;
            ack_q     <= next_ack_q;
            rdata_q   <= next_rdata_q;
            cmd_cnt   <= next_cmd_cnt;
            code_q    <= next_code_q;
            len_q     <= next_len_q;
            start_q   <= next_start_q;
            bad_q     <= next_bad_q;
            bv_q      <= next_bv_q;
            byte_q    <= next_byte_q;
            cnt       <= next_cnt;
            size      <= next_size;
            pop_q     <= next_pop_q;
            done_q    <= next_done_q;
            flush_q   <= next_flush_q;
            tspkt_q   <= next_tspkt_q;
        end
    end

    assign link.ack       = ack_q;
    assign link.rdata     = rdata_q;
    assign link.irq       = irq_q;
    assign turbo_allowed  = ~turbo_off;
    assign err_clear      = clr_q;
    assign cmd_start      = start_q;
    assign cmd_code       = code_q;
    assign cmd_len        = len_q;
    assign cmd_bad        = bad_q;
    assign cmd_byte_valid = bv_q;
    assign cmd_byte       = byte_q;
    assign chan_pop       = pop_q;
    assign chan_done      = done_q;
    assign chan_flush     = flush_q;
    assign status_async   = ctl[shh_pkg::LINK_ASYNC];
    assign ts_event_pkt   = tspkt_q;
endmodule : shh_device

// *** hdl/shh_host.sv ***
// Host end: AHB-Lite controlled byte access to the sensor hub registers
`timescale 1ns/1ps
module shh_host #(
    parameter int ABORT_HOLD = shh_pkg::ABORT_HOLD_CYC
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq_out,
    shh_link_if.host         link
);
    // ========================================================================
    // State
    shh_pkg::shh_host_state_t state,     next_state;
    logic [31:0] hrdata_q,  next_hrdata_q;
    logic        dw_q,      next_dw_q;
    logic [31:0] da_q,      next_da_q;
    logic        req_q,     next_req_q;
    logic        wr_q,      next_wr_q;
    logic [6:0]  addr_q,    next_addr_q;
    logic [7:0]  wdata_q,   next_wdata_q;
    logic [7:0]  last_q,    next_last_q;
    logic        refused,   next_refused;
    logic [3:0]  abort_q,   next_abort_q;
    logic [31:0] hold_cnt,  next_hold_cnt;
    logic        ap;
    logic        go;
    logic [6:0]  c_addr;
    logic        c_wr;
    logic [7:0]  c_wd;
    logic        early_clear;

    assign ap     = hsel & htrans[1] & hready;
    assign go     = dw_q & (da_q == shh_pkg::HREG_CMD);
    assign c_addr = hwdata[shh_pkg::HCMD_ADDR +: 7];
    assign c_wr   = hwdata[shh_pkg::HCMD_WR];
    assign c_wd   = hwdata[shh_pkg::HCMD_WDATA +: 8];
    // Clearing an abort bit too soon after any abort bit was last newly set
    assign early_clear = c_wr && c_addr == shh_pkg::OFF_LINK &&
                         (abort_q & ~c_wd[3:0]) != 4'h0 && hold_cnt < 32'(ABORT_HOLD);

    always_comb begin
        next_state    = state;
        next_hrdata_q = hrdata_q;
        next_dw_q     = ap & hwrite;
        next_da_q     = ap ? {haddr[31:2], 2'b00} : da_q;
        next_req_q    = req_q;
        next_wr_q     = wr_q;
        next_addr_q   = addr_q;
        next_wdata_q  = wdata_q;
        next_last_q   = last_q;
        next_refused  = refused;
        next_abort_q  = abort_q;
        next_hold_cnt = (hold_cnt < 32'(ABORT_HOLD)) ? hold_cnt + 32'h1 : hold_cnt;
        if (ap && !hwrite) begin
            if ({haddr[31:2], 2'b00} == shh_pkg::HREG_CMD) begin
                next_hrdata_q = {15'h0000, wr_q, 1'b0, addr_q, wdata_q};
            end else if ({haddr[31:2], 2'b00} == shh_pkg::HREG_STAT) begin
                next_hrdata_q = {21'h000000, refused, link.irq,
                                 state == shh_pkg::SHH_BUSY, last_q};
            end else begin
                next_hrdata_q = 32'h0000_0000;
            end
        end
        if (dw_q && da_q == shh_pkg::HREG_STAT) begin
            next_refused = 1'b0;
        end
        unique case (state)
            shh_pkg::SHH_IDLE: begin
                if (go) begin
                    if (c_addr == shh_pkg::OFF_RSVD || early_clear) begin
                        next_refused = 1'b1;
                    end else begin
                        next_state   = shh_pkg::SHH_BUSY;
                        next_req_q   = 1'b1;
                        next_wr_q    = c_wr;
                        next_addr_q  = c_addr;
                        next_wdata_q = c_wd;
                        if (c_wr && c_addr == shh_pkg::OFF_LINK) begin
                            next_abort_q = c_wd[3:0];
                            if ((c_wd[3:0] & ~abort_q) != 4'h0) begin
                                next_hold_cnt = 32'h0;
                            end
                        end
                    end
                end
            end
            shh_pkg::SHH_BUSY: begin
                if (go) begin
                    next_refused = 1'b1;
                end
                if (link.ack) begin
                    next_state  = shh_pkg::SHH_IDLE;
                    next_req_q  = 1'b0;
                    next_last_q = link.rdata;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state    <= shh_pkg::SHH_IDLE;
            hrdata_q <= 32'h0000_0000;
            dw_q     <= 1'b0;
            da_q     <= 32'h0000_0000;
            req_q    <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= 7'h00;
            wdata_q  <= 8'h00;
            last_q   <= 8'h00;
            refused  <= 1'b0;
            abort_q  <= 4'h0;
            hold_cnt <= 32'(ABORT_HOLD);
        end else begin
            state    <= next_state;
            hrdata_q <= next_hrdata_q;
            dw_q     <= next_dw_q;
            da_q     <= next_da_q;
            req_q    <= next_req_q;
            wr_q     <= next_wr_q;
            addr_q   <= next_addr_q;
            wdata_q  <= next_wdata_q;
            last_q   <= next_last_q;
            refused  <= next_refused;
            abort_q  <= next_abort_q;
            hold_cnt <= next_hold_cnt;
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_q;
    assign irq_out    = link.irq;
    assign link.req   = req_q;
    assign link.wr    = wr_q;
    assign link.addr  = addr_q;
    assign link.wdata = wdata_q;
endmodule : shh_host

// *** tb/shh_link_chk.sv ***
// Assertions on the byte link between host end and device end
`timescale 1ns/1ps
module shh_link_chk (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       req,
    input wire logic       wr,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // ========================================================================
    // Link handshake
    sequence s_take;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 (!ack && !req);
    endsequence
    a_ack_next: assert property (s_take |=> s_answer)
        else $error("link answer not one pulse one cycle after take");
    a_req_held: assert property (s_take |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
        else $error("link request changed before answer");
    a_ack_caused: assert property (!req |=> !ack)
        else $error("link answer without request");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !req && !ack && !irq)
        else $error("link active during reset");
    // ========================================================================
    // Register map
    a_rsvd_untouched: assert property (req |-> addr != shh_pkg::OFF_RSVD)
        else $error("reserved offset accessed");
    a_core_rsvd_zero: assert property (ack && !wr && addr == shh_pkg::OFF_CORE |-> rdata[7:1] == 7'h0)
        else $error("core control spare bits not zero");
    a_link_rsvd_zero: assert property (ack && !wr && addr == shh_pkg::OFF_LINK |-> !rdata[5])
        else $error("link control bit 5 not zero");
    a_unmapped_zero: assert property (ack && !wr && addr >= 7'h3e |-> rdata == 8'h00)
        else $error("unmapped offset not zero");
endmodule : shh_link_chk

// *** tb/tb_sensor_hub_host_channel_regs.sv ***
// Testbench joining host and device ends through the byte link
`timescale 1ns/1ps
module tb_sensor_hub_host_channel_regs;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        err_wr = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'h3d;
    logic [39:0] ts_now = 40'h0;
    logic [15:0] chan_len [3] = '{default: 16'h0};
    logic [7:0]  chan_byte [3] = '{default: 8'h0};
    logic [7:0]  q [3][$];
    logic [7:0]  e [$];
    logic [31:0] hrdata, r32, r_stat;
    logic [15:0] cmd_code, cmd_len;
    logic [2:0]  chan_pop;
    logic [7:0]  b;
    logic        hreadyout, irq_out, turbo_allowed, status_async;
    logic        err_clear, cmd_bad, cmd_bv, ts_pkt;
    logic [7:0]  cmd_byte;
    logic [2:0]  chan_done;
    logic [3:0]  chan_flush, flushes = 4'h0;
    logic [39:0] exp_ts;
    int          n_clr = 0, n_bad = 0, n_bv = 0, n_done = 0, n_pkt = 0;
    int          mismatches = 0;
    int          check_count = 0;
    int          n;

    shh_link_if u_shh_link_if ();
    shh_device u_shh_device (.clock(clock), .nrst(nrst), .link(u_shh_link_if),
        .turbo_allowed(turbo_allowed), .err_clear(err_clear), .err_wr(err_wr), .err_idx(2'h0),
        .err_data(8'h5a), .cmd_start(), .cmd_code(cmd_code), .cmd_len(cmd_len),
        .cmd_bad(cmd_bad), .cmd_byte_valid(cmd_bv), .cmd_byte(cmd_byte), .chan_len(chan_len),
        .chan_byte(chan_byte), .chan_pop(chan_pop), .chan_done(chan_done),
        .chan_flush(chan_flush), .status_async(status_async), .ts_now(ts_now),
        .ts_event_pkt(ts_pkt));
    shh_host #(.ABORT_HOLD(20)) u_shh_host (.clock(clock), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .irq_out(irq_out), .link(u_shh_link_if));
    shh_link_chk u_chk (.clock(clock), .nrst(nrst), .req(u_shh_link_if.req),
        .wr(u_shh_link_if.wr), .addr(u_shh_link_if.addr), .wdata(u_shh_link_if.wdata),
        .rdata(u_shh_link_if.rdata), .ack(u_shh_link_if.ack), .irq(u_shh_link_if.irq));

    always #4 clock = ~clock;

    // Core side of the output channels; stale byte inverted once drained
    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if (chan_pop[i] && q[i].size() > 0) begin
                void'(q[i].pop_front());
            end
            chan_len[i] <= 16'(q[i].size());
            chan_byte[i] <= (q[i].size() > 0) ? q[i][0] : ~chan_byte[i];
        end
        ts_now <= ts_now + 40'h1;
        if (nrst) begin
            n_clr   <= n_clr + int'(err_clear);
            n_bad   <= n_bad + int'(cmd_bad);
            n_bv    <= n_bv + int'(cmd_bv);
            n_done  <= n_done + $countones(chan_done);
            n_pkt   <= n_pkt + int'(ts_pkt);
            flushes <= flushes | chan_flush;
        end
        // Ceiling far above the few hundred cycles the tests need
        if (ts_now == 40'h4e20) begin
            mismatches++;
            stop_test();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    // One link access; four cycles covers the walk to busy low
    task automatic dev_io(input logic w, input logic [6:0] off, input logic [7:0] d);
        ahb(1'b1, shh_pkg::HREG_CMD, {15'h0, w, 1'b0, off, d}, r32);
        repeat (4) @(posedge clock);
        ahb(1'b0, shh_pkg::HREG_STAT, 32'h0, r_stat);
        b = r_stat[7:0];
    endtask : dev_io

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        err_wr <= 1'b1;
        @(posedge clock);
        err_wr <= 1'b0;
        dev_io(1'b0, shh_pkg::OFF_LINK, 8'h0);
        chk(b, shh_pkg::LINK_RESET);
        dev_io(1'b0, shh_pkg::OFF_ERR0, 8'h0);
        chk(b, 8'h5a);
        dev_io(1'b1, shh_pkg::OFF_CORE, 8'hff);
        chk(turbo_allowed, 1'b0);
        dev_io(1'b0, shh_pkg::OFF_CORE, 8'h0);
        chk(b, 8'h01);
        dev_io(1'b0, shh_pkg::OFF_ERR0, 8'h0);
        chk(b, 8'h00);
        dev_io(1'b1, shh_pkg::OFF_CORE, 8'h00);
        chk(turbo_allowed, 1'b1);
        chk(16'(n_clr), 16'h1);
        $display("test core control done");
        dev_io(1'b1, shh_pkg::OFF_LINK, 8'hff);
        dev_io(1'b1, shh_pkg::OFF_LINK, 8'h00);
        chk(r_stat[10], 1'b1);
        chk(status_async, 1'b1);
        dev_io(1'b0, shh_pkg::OFF_LINK, 8'h0);
        chk(b, 8'hdf);
        repeat (20) @(posedge clock);
        ahb(1'b1, shh_pkg::HREG_STAT, 32'h0, r32);
        dev_io(1'b1, shh_pkg::OFF_LINK, 8'h10);
        chk(r_stat[10], 1'b0);
        chk(16'(flushes), 16'hf);
        $display("test link control done");
        for (int c = 0; c < 3; c++) begin
            n = 1 + int'(seed[1:0]);
            for (int k = 0; k < n; k++) begin
                seed = xs(seed);
                q[c].push_back(seed[7:0]);
                e.push_back(seed[7:0]);
            end
            repeat (3) @(posedge clock);
            chk(irq_out, c != 1);
            dev_io(1'b0, 7'(c + 1), 8'h0);
            chk(b, 16'(n));
            dev_io(1'b0, 7'(c + 1), 8'h0);
            chk(b, 16'h0);
            for (int k = 0; k < n; k++) begin
                dev_io(1'b0, 7'(c + 1), 8'h0);
                chk(b, e.pop_front());
            end
            for (int k = 0; k < 2; k++) begin
                dev_io(1'b0, 7'(c + 1), 8'h0);
                chk(b, 16'h0);
            end
        end
        chk(16'(n_done), 16'h6);
        // Abort hides pending wake-up data; clearing it brings the data back
        q[0].push_back(seed[15:8]);
        repeat (3) @(posedge clock);
        chk(irq_out, 1'b1);
        dev_io(1'b1, shh_pkg::OFF_LINK, 8'h12);
        chk(irq_out, 1'b0);
        repeat (20) @(posedge clock);
        dev_io(1'b1, shh_pkg::OFF_LINK, 8'h10);
        chk(irq_out, 1'b1);
        dev_io(1'b0, shh_pkg::OFF_WAKE, 8'h0);
        chk(b, 16'(q[0].size()));
        $display("test output channels done");
        dev_io(1'b0, shh_pkg::OFF_RSVD, 8'h0);
        chk(r_stat[10], 1'b1);
        dev_io(1'b0, 7'h7f, 8'h0);
        chk(b, 8'h00);
        dev_io(1'b1, shh_pkg::OFF_CMD, 8'h34);
        dev_io(1'b1, shh_pkg::OFF_CMD, 8'h12);
        dev_io(1'b1, shh_pkg::OFF_CMD, 8'h04);
        dev_io(1'b1, shh_pkg::OFF_CMD, 8'h00);
        chk(cmd_code, 16'h1234);
        chk(cmd_len, 16'h0004);
        for (int k = 0; k < 4; k++) begin
            dev_io(1'b1, shh_pkg::OFF_CMD, 8'(k + 1));
        end
        chk(cmd_byte, 16'h4);
        chk(16'(n_bv), 16'h4);
        for (int k = 0; k < 4; k++) begin
            dev_io(1'b1, shh_pkg::OFF_CMD, 8'(32'h0002_0001 >> (8 * k)));
        end
        chk(16'(n_bad), 16'h1);
        dev_io(1'b1, shh_pkg::OFF_TSREQ, 8'h0);
        dev_io(1'b1, shh_pkg::OFF_LINK, 8'h50);
        ahb(1'b1, shh_pkg::HREG_CMD, {15'h0, 1'b1, 1'b0, shh_pkg::OFF_TSREQ, 8'h0}, r32);
        // Device takes the request one edge after the command lands
        exp_ts = ts_now + 40'h1;
        repeat (4) @(posedge clock);
        dev_io(1'b0, shh_pkg::OFF_TS0, 8'h0);
        chk(b, 16'(exp_ts[7:0]));
        chk(16'(n_pkt), 16'h1);
        $display("test reserved and command done");
        stop_test();
    end
endmodule : tb_sensor_hub_host_channel_regs
